/* File: rtl/afm_pkg.sv */
// afm_pkg: constants for the graphics-port frame, pipe and sideband bus signal block
// assumes: single 200 MHz clock, active-low bus encodings
package afm_pkg;
  localparam int unsigned AD_W   = 32;
  localparam int unsigned CBE_W  = 4;
  localparam int unsigned ST_W   = 3;

  // operating modes of the port
  typedef enum logic [2:0] {
    AFM_MODE_FRAME = 3'h1,
    AFM_MODE_PIPE  = 3'h2,
    AFM_MODE_SBA   = 3'h4
  } afm_mode_t;

  // frame-based commands (pci encoding)
  localparam logic [3:0] CMD_MEM_RD  = 4'h6;
  localparam logic [3:0] CMD_MEM_WR  = 4'h7;
  // pipelined commands use their own encoding
  localparam logic [3:0] PCMD_RD     = 4'h0;
  localparam logic [3:0] PCMD_WR     = 4'h4;

  // status bus codes sent with grant
  localparam logic [2:0] ST_RD_DATA  = 3'h0;
  localparam logic [2:0] ST_WR_DATA  = 3'h2;
  localparam logic [2:0] ST_MASTER   = 3'h7;

  localparam logic [AD_W-1:0] MEM_BASE_DEF  = 32'h0000_0000;
  localparam logic [AD_W-1:0] MEM_LIMIT_DEF = 32'h0FFF_FFFF;
endpackage

/* File: rtl/afm_parity.sv */
// afm_parity: even parity over address/data and command/byte-enable lines
// assumes: inputs are the values actually on the bus in the covered phase
`timescale 1ns/10ps
module afm_parity
  import afm_pkg::*;
(
  input  wire logic [AD_W-1:0]  ad,   // address/data value
  input  wire logic [CBE_W-1:0] cbe,  // command/byte-enable value
  output logic                  par   // parity bit
);
  assign par = ^{ad, cbe};
endmodule

/* File: rtl/afm_bus.sv */
// afm_bus: device end of the graphics-port frame, pipe and sideband signals
// assumes: frame, ready and stop handshakes handled by a neighbour block
`timescale 1ns/10ps
import afm_pkg::*;

// What this block does
// - as frame target, claim accesses whose address falls in decoded memory range.
// - as initiator, read target_claim_n as whether any agent claimed the access.
// - target_claim_n means nothing and is ignored in pipe and sideband modes.
// - grant goes out with a status code telling how the bus is used next.
// - ad carries address and data in frame/pipe modes, only data in sideband.
// - frame mode: command in address phase, byte enables in data phases.
// - pipelined enqueue carries commands with their own distinct encoding.
// - cmd_byte_en_n lines are unused in sideband mode.
// - as frame initiator, drive parity on write address/data, read address only.
// - as frame target, drive parity on each data phase of a memory read.
// - parity is even over 32 ad lines and 4 cmd_byte_en_n lines.
// - bus_parity is unused in pipe and sideband modes.
// - no lock, system error or parity error signals on this port.
// - pci transactions on this port follow pci 2.1 signalling.
// - as frame target, capture command and address on first frame-low edge.
module afm_bus
  import afm_pkg::*;
(
  input  wire logic             clk,             // 200 MHz clock
  input  wire logic             rst,             // async reset, high
  input  wire afm_mode_t        mode,            // current port mode
  input  wire logic [AD_W-1:0]  mem_base,        // decoded range base
  input  wire logic [AD_W-1:0]  mem_limit,       // decoded range limit
  input  wire logic             frame_n,         // frame from bus
  input  wire logic             irdy_n,          // initiator ready from bus
  input  wire logic             trdy_n,          // target ready (from bus or neighbour)
  input  wire logic             req_n,           // request from master
  input  wire logic             grant_req,       // core wants to grant bus
  input  wire logic [ST_W-1:0]  grant_st,        // status code for grant
  input  wire logic             tgt_data_phase,  // neighbour drives read data now
  input  wire logic             ini_addr_phase,  // own initiator address phase
  input  wire logic             ini_data_phase,  // own initiator data phase
  input  wire logic             ini_write,       // own initiator cycle is a write
  input  wire logic [AD_W-1:0]  ini_ad,          // own address/data to drive
  input  wire logic [CBE_W-1:0] ini_cbe_n,       // own command or byte enables
  input  wire logic [AD_W-1:0]  tgt_rdata,       // read data for target cycles
  input  wire logic [AD_W-1:0]  ad_in,           // ad pins in
  input  wire logic [CBE_W-1:0] cmd_byte_en_n_in, // cbe pins in
  input  wire logic             target_claim_n_in, // claim pin in
  output logic [AD_W-1:0]       ad_out,          // ad pins out
  output logic                  ad_oe,           // ad output enable
  output logic [CBE_W-1:0]      cmd_byte_en_n_out, // cbe pins out
  output logic                  cmd_byte_en_n_oe, // cbe output enable
  output logic                  target_claim_n_out, // claim pin out
  output logic                  target_claim_n_oe, // claim output enable
  output logic                  bus_parity_out,  // parity pin out
  output logic                  bus_parity_oe,   // parity output enable
  output logic                  gnt_n,           // grant to master
  output logic [ST_W-1:0]       st,              // status bus
  output logic                  master_req,      // registered master request
  output logic                  ini_claimed,     // some agent claimed own access
  output logic                  tgt_hit,         // current target cycle is ours
  output logic [AD_W-1:0]       tgt_addr,        // captured target address
  output logic [CBE_W-1:0]      tgt_cmd,         // captured target command
  output logic [CBE_W-1:0]      tgt_be_n         // latest target byte enables
);
  logic frame_mode;
  logic frame_d_r;
  logic first_frame;
  logic par_calc;
  logic par_due_r;
  logic [AD_W-1:0]  par_ad_r;
  logic [CBE_W-1:0] par_cbe;
  logic [AD_W-1:0]  drv_ad_nxt;
  logic [CBE_W-1:0] drv_cbe_nxt;
  logic drv_ad_en;
  logic drv_cbe_en;
  logic par_en;
  logic in_range;

  assign frame_mode  = (mode == AFM_MODE_FRAME);
  assign first_frame = frame_mode && !frame_n && frame_d_r;
  assign in_range    = (ad_in >= mem_base) && (ad_in <= mem_limit);
  // cbe as it stands on the pins during the covered phase, ours or the master's
  assign par_cbe     = cmd_byte_en_n_oe ? cmd_byte_en_n_out : cmd_byte_en_n_in;

  ////////////////////////////////////////////////////////////////////////////
  // target address phase capture and decode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frame_d_r <= 1'b1;
    end else begin
      frame_d_r <= frame_n;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tgt_addr <= '0;
      tgt_cmd  <= '0;
      tgt_hit  <= 1'b0;
    end else if (first_frame && !ini_addr_phase) begin
      tgt_addr <= ad_in;
      tgt_cmd  <= cmd_byte_en_n_in;
      tgt_hit  <= in_range;
    end else if (frame_n && irdy_n) begin
      tgt_hit  <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tgt_be_n <= '1;
    end else if (frame_mode && tgt_hit && !irdy_n) begin
      tgt_be_n <= cmd_byte_en_n_in;
    end
  end

  // claim driven only in frame mode; released one clock after the cycle ends
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      target_claim_n_out <= 1'b1;
      target_claim_n_oe  <= 1'b0;
    end else if (!frame_mode) begin
      target_claim_n_out <= 1'b1;
      target_claim_n_oe  <= 1'b0;
    end else if (first_frame && !ini_addr_phase && in_range) begin
      target_claim_n_out <= 1'b0;
      target_claim_n_oe  <= 1'b1;
    end else if (tgt_hit && frame_n && !trdy_n) begin
      target_claim_n_out <= 1'b1;
      target_claim_n_oe  <= 1'b1;
    end else if (!tgt_hit) begin
      target_claim_n_out <= 1'b1;
      target_claim_n_oe  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // initiator side: claim sensing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ini_claimed <= 1'b0;
    end else if (!frame_mode || ini_addr_phase) begin
      ini_claimed <= 1'b0;
    end else if (!target_claim_n_in) begin
      ini_claimed <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // arbitration: request in, grant with status out
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      master_req <= 1'b0;
      gnt_n      <= 1'b1;
      st         <= ST_MASTER;
    end else begin
      master_req <= !req_n && (mode != AFM_MODE_SBA);
      gnt_n      <= !grant_req;
      st         <= grant_req ? grant_st : ST_MASTER;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ad and cbe drive
  always_comb begin
    drv_ad_en   = 1'b0;
    drv_cbe_en  = 1'b0;
    drv_ad_nxt  = ini_ad;
    drv_cbe_nxt = ini_cbe_n;
    par_en      = 1'b0;
    if (frame_mode && (ini_addr_phase || (ini_data_phase && ini_write))) begin
      drv_ad_en  = 1'b1;
      drv_cbe_en = 1'b1;
      par_en     = 1'b1;
    end else if (frame_mode && ini_data_phase) begin
      drv_cbe_en = 1'b1;
    end else if (frame_mode && tgt_hit && tgt_data_phase && tgt_cmd == CMD_MEM_RD) begin
      drv_ad_en  = 1'b1;
      drv_ad_nxt = tgt_rdata;
      par_en     = 1'b1;
    end else if (mode == AFM_MODE_PIPE && ini_addr_phase) begin
      drv_ad_en  = 1'b1;
      drv_cbe_en = 1'b1;
    end else if (mode != AFM_MODE_FRAME && ini_data_phase && ini_write) begin
      drv_ad_en  = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ad_out            <= '0;
      ad_oe             <= 1'b0;
      cmd_byte_en_n_out <= '1;
      cmd_byte_en_n_oe  <= 1'b0;
    end else begin
      ad_out            <= drv_ad_nxt;
      ad_oe             <= drv_ad_en;
      cmd_byte_en_n_out <= drv_cbe_nxt;
      cmd_byte_en_n_oe  <= drv_cbe_en && (mode != AFM_MODE_SBA);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // parity: covers the phase driven one clock earlier
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      par_due_r <= 1'b0;
      par_ad_r  <= '0;
    end else begin
      par_due_r <= par_en && frame_mode;
      par_ad_r  <= drv_ad_nxt;
    end
  end

  afm_parity u_par (
    .ad  (par_ad_r),
    .cbe (par_cbe),
    .par (par_calc)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_parity_out <= 1'b0;
      bus_parity_oe  <= 1'b0;
    end else begin
      bus_parity_out <= par_calc;
      bus_parity_oe  <= par_due_r && frame_mode;
    end
  end
  // no lock, system error or parity error pins exist on this port
endmodule

/* File: sim/afm_chk.sv */
// afm_chk: port assertions for afm_bus
// assumes: bound to afm_bus, single clock, async high reset
`timescale 1ns/10ps
module afm_chk
  import afm_pkg::*;
(
  input wire logic        clk,                // clock
  input wire logic        rst,                // reset
  input wire afm_mode_t   mode,               // mode
  input wire logic [31:0] mem_base,           // range base
  input wire logic [31:0] mem_limit,          // range limit
  input wire logic        frame_n,            // frame
  input wire logic        ini_addr_phase,     // own addr phase
  input wire logic        ini_write,          // own write
  input wire logic [31:0] ini_ad,             // own ad
  input wire logic        tgt_data_phase,     // target data
  input wire logic        tgt_hit,            // decoded ours
  input wire logic [31:0] tgt_rdata,          // read data
  input wire logic        grant_req,          // grant ask
  input wire logic [2:0]  grant_st,           // grant code
  input wire logic [31:0] ad_in,              // ad wire
  input wire logic [3:0]  cmd_byte_en_n_in,   // cbe wire
  input wire logic [31:0] ad_out,             // ad out
  input wire logic        ad_oe,              // ad enable
  input wire logic        cmd_byte_en_n_oe,   // cbe enable
  input wire logic        target_claim_n_out, // claim out
  input wire logic        target_claim_n_oe,  // claim enable
  input wire logic        bus_parity_out,     // parity out
  input wire logic        bus_parity_oe,      // parity enable
  input wire logic        gnt_n,              // grant
  input wire logic [2:0]  st                  // status
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  sequence s_tgt_start;
    mode == AFM_MODE_FRAME && $fell(frame_n) && !ini_addr_phase;
  endsequence
  sequence s_rd_drive;
    ad_oe && ad_out == $past(tgt_rdata);
  endsequence
  AST_CLAIM: assert property (s_tgt_start ##0 (ad_in >= mem_base && ad_in <= mem_limit)
    |=> !target_claim_n_out && target_claim_n_oe && tgt_hit) else $error("claim missing");
  AST_NO_CLAIM: assert property ((mode != AFM_MODE_FRAME) [*2] |-> !target_claim_n_oe)
    else $error("claim outside frame mode");
  AST_GRANT: assert property (grant_req |=> !gnt_n && st == $past(grant_st))
    else $error("grant or status wrong");
  AST_PARITY: assert property (bus_parity_oe
    |-> bus_parity_out == ^{$past(ad_in), $past(cmd_byte_en_n_in)}) else $error("bad parity");
  AST_NO_PARITY: assert property ((mode != AFM_MODE_FRAME) [*3] |-> !bus_parity_oe)
    else $error("parity outside frame mode");
  AST_SBA_CBE: assert property ((mode == AFM_MODE_SBA) [*2] |-> !cmd_byte_en_n_oe)
    else $error("cbe driven in sideband");
  AST_TGT_READ: assert property (tgt_data_phase && tgt_hit && mode == AFM_MODE_FRAME
    |=> s_rd_drive ##1 bus_parity_oe) else $error("target read drive wrong");
  AST_INI_WRITE: assert property (ini_addr_phase && ini_write && mode == AFM_MODE_FRAME
    |=> ad_oe && cmd_byte_en_n_oe && ad_out == $past(ini_ad) ##1 bus_parity_oe)
    else $error("initiator write drive wrong");
endmodule

/* File: sim/afm_gfx_model.sv */
// afm_gfx_model: external graphics controller on the far side of the port
// assumes: tasks are called just after a falling clock edge
`timescale 1ns/10ps
module afm_gfx_model (
  output logic        frame_n,   // frame
  output logic        irdy_n,    // initiator ready
  output logic        trdy_n,    // target ready
  output logic        req_n,     // bus request
  output logic [31:0] p_ad,      // ad drive
  output logic [3:0]  p_cbe,     // cbe drive
  output logic        p_claim_n  // claim drive, pulled up
);
  initial begin
    {frame_n, irdy_n, trdy_n, req_n, p_claim_n} = 5'h1F;
    p_ad = 32'h0;
    p_cbe = 4'hF;
  end
  task automatic req(input logic v);
    req_n = ~v;
  endtask
  task automatic addr(input logic [31:0] a, input logic [3:0] c);
    frame_n = 1'h0;
    p_ad = a;
    p_cbe = c;
  endtask
  task automatic data(input logic [3:0] be);
    {frame_n, irdy_n} = 2'h2;
    p_ad = ~p_ad;
    p_cbe = be;
  endtask
  task automatic tgt_rdy();
    trdy_n = 1'h0;
  endtask
  task automatic claim();
    p_claim_n = 1'h0;
  endtask
  // released ad and cbe lines flip so a stale value is never mistaken for a drive
  task automatic idle();
    {irdy_n, trdy_n, p_claim_n} = 3'h7;
    p_ad = ~p_ad;
    p_cbe = ~p_cbe;
  endtask
endmodule

/* File: sim/tb.sv */
// tb: self-checking bench for afm_bus
// assumes: 200 MHz clock, bus inputs driven at the falling edge
`timescale 1ns/10ps
module tb;
  import afm_pkg::*;
  logic clk = 1'h0, rst = 1'h1, grant_req = 1'h0, tgt_data_phase = 1'h0;
  logic ini_addr_phase = 1'h0, ini_data_phase = 1'h0, ini_write = 1'h0;
  logic [2:0] grant_st = 3'h0;
  logic [3:0] ini_cbe_n = 4'hF;
  logic [31:0] ini_ad = 32'h0, tgt_rdata = 32'h0, mem_base = 32'h0, mem_limit = 32'h0FFF_FFFF;
  afm_mode_t mode = AFM_MODE_FRAME;
  logic frame_n, irdy_n, trdy_n, req_n, p_claim_n, target_claim_n_in, target_claim_n_out;
  logic target_claim_n_oe, ad_oe, cmd_byte_en_n_oe, bus_parity_out, bus_parity_oe, gnt_n;
  logic master_req, ini_claimed, tgt_hit;
  logic [2:0] st;
  logic [3:0] p_cbe, cmd_byte_en_n_in, cmd_byte_en_n_out, tgt_cmd, tgt_be_n;
  logic [31:0] p_ad, ad_in, ad_out, tgt_addr;
  int num_errors = 0, comparisons = 0;
  afm_bus dut_u (.*);
  afm_gfx_model gfx_u (.*);
  assign ad_in = ad_oe ? ad_out : p_ad;
  assign cmd_byte_en_n_in = cmd_byte_en_n_oe ? cmd_byte_en_n_out : p_cbe;
  assign target_claim_n_in = target_claim_n_oe ? target_claim_n_out : p_claim_n;
  always #2.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic t_grant();
    for (int i = 0; i < 8; i++) begin
      grant_req = 1'h1;
      grant_st = i[2:0];
      @(negedge clk);
      chk(gnt_n, 1'h0);
      chk(st, i[2:0]);
    end
    grant_req = 1'h0;
    @(negedge clk);
    chk({gnt_n, st}, {1'h1, ST_MASTER});
  endtask
  task automatic t_reset();
    {grant_req, grant_st} = {1'h1, ST_WR_DATA};
    @(negedge clk);
    rst = 1'h1;
    @(negedge clk);
    chk({gnt_n, st, ad_oe, bus_parity_oe}, {1'h1, ST_MASTER, 2'h0});
    rst = 1'h0;
    @(negedge clk);
    chk({gnt_n, st}, {1'h0, ST_WR_DATA});
    grant_req = 1'h0;
    @(negedge clk);
  endtask
  task automatic t_tgt(input logic [31:0] a, input logic hit);
    gfx_u.addr(a, CMD_MEM_RD);
    @(negedge clk);
    chk(target_claim_n_oe, hit);
    if (mode == AFM_MODE_FRAME) chk({tgt_hit, tgt_cmd, tgt_addr}, {hit, CMD_MEM_RD, a});
    gfx_u.data(4'h3);
    tgt_data_phase = hit;
    tgt_rdata = a ^ 32'h5A5A_0F0F;
    @(negedge clk);
    if (hit) chk(ad_out, a ^ 32'h5A5A_0F0F);
    if (hit) chk(tgt_be_n, 4'h3);
    tgt_data_phase = 1'h0;
    gfx_u.tgt_rdy();
    @(negedge clk);
    chk(bus_parity_oe, hit);
    if (hit) chk(bus_parity_out, ^{a ^ 32'h5A5A_0F0F, 4'h3});
    if (hit) chk(target_claim_n_out, 1'h1);
    gfx_u.idle();
    @(negedge clk);
  endtask
  task automatic t_ini(input logic w, input logic [31:0] a, input logic [31:0] d);
    logic [3:0] c;
    c = w ? CMD_MEM_WR : CMD_MEM_RD;
    {ini_addr_phase, ini_write, ini_ad, ini_cbe_n} = {1'h1, w, a, c};
    @(negedge clk);
    chk({ad_oe, ad_out, cmd_byte_en_n_out}, {1'h1, a, c});
    {ini_addr_phase, ini_data_phase, ini_ad, ini_cbe_n} = {2'h1, d, 4'h0};
    gfx_u.claim();
    @(negedge clk);
    chk(bus_parity_out, ^{a, c});
    chk(ini_claimed, 1'h1);
    chk({ad_oe, cmd_byte_en_n_oe, cmd_byte_en_n_out}, {w, 1'h1, 4'h0});
    ini_data_phase = 1'h0;
    @(negedge clk);
    chk(bus_parity_oe, w);
    if (w) chk(bus_parity_out, ^d);
    gfx_u.idle();
  endtask
  task automatic t_modes();
    mode = AFM_MODE_PIPE;
    gfx_u.req(1'h1);
    repeat (2) @(negedge clk);
    chk(master_req, 1'h1);
    t_tgt(32'h0000_0040, 1'h0);
    {ini_addr_phase, ini_ad, ini_cbe_n} = {1'h1, 32'h0000_3000, PCMD_WR};
    @(negedge clk);
    chk({ad_oe, cmd_byte_en_n_oe, ad_out, cmd_byte_en_n_out}, {2'h3, 32'h3000, PCMD_WR});
    ini_addr_phase = 1'h0;
    @(negedge clk);
    chk(bus_parity_oe, 1'h0);
    mode = AFM_MODE_SBA;
    repeat (2) @(negedge clk);
    chk(master_req, 1'h0);
    {ini_addr_phase, ini_data_phase, ini_write} = 3'h7;
    @(negedge clk);
    chk(cmd_byte_en_n_oe, 1'h0);
    chk(ad_oe, 1'h1);
    {ini_addr_phase, ini_data_phase, ini_write} = 3'h0;
    t_grant();
    mode = AFM_MODE_FRAME;
  endtask
  initial begin
    #10000;
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'h0;
    t_grant();
    t_tgt(32'h0FFF_FFFC, 1'h1);
    t_tgt(32'h1000_0000, 1'h0);
    t_ini(1'h1, 32'h0000_1000, 32'hA5A5_1234);
    t_ini(1'h0, 32'h0000_2000, 32'h0);
    t_modes();
    t_reset();
    complete_run();
  end
endmodule
bind afm_bus afm_chk chk_u (.*);
